// *** hw/oiag_addr_gen.sv ***
// operand address generator with indexing, octal relays and buffer memory
`timescale 1ns/1ps
`default_nettype none
`include "oiag_regs.svh"
// Operation
// - buffer memory operand takes unit 0..7 and word 0..32766.
// - buffer memory operand is 16-bit or 32-bit as the instruction says.
// - buffer word number may be offset by an index register.
// - basic-instruction bit operands X, Y, M, T, C0..C199 may be indexed.
// - sixteen index registers, eight low and eight high, numbered 0..7.
// - effective number is base plus index value.
// - 32-bit counters and special relays refuse indexing in basic instructions.
// - an indexed 16-bit counter never resolves to a 32-bit counter.
// - input and output relay operands add the index in octal.
// - coil number and set-value device are indexed independently.
// - a 32-bit counter coil never indexes its set value.
// - applied-instruction bit operands are indexed the same way.
// - only the buffer word number, never the unit, is indexed.
// - 32-bit instructions pair low and high registers of the same number.
module oiag_addr_gen import oiag_pkg::*; #(
  parameter int NUM_IDX = `OIAG_IDX_REGS
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic rstn_i, // async reset, active low
  input wire logic ce_i, // clock enable, freezes all state
  input wire logic idx_we_i, // index register write strobe
  input wire logic [2:0] idx_wsel_i, // index register number
  input wire logic idx_whigh_i, // write the high kind
  input wire logic idx_wwide_i, // 32-bit write of a pair
  input wire logic [31:0] idx_wdata_i, // index write data
  input wire logic req_valid_i, // operand request
  input wire oiag_class_e req_class_i, // operand device class
  input wire logic [15:0] req_base_i, // base number, input and output relays octal per nibble
  input wire logic [2:0] req_unit_i, // buffer memory unit select
  input wire logic req_idx_en_i, // operand is indexed
  input wire logic [2:0] req_idx_sel_i, // index register number
  input wire logic req_idx_high_i, // use the high kind (16-bit)
  input wire logic req_wide_i, // 32-bit instruction
  input wire logic req_basic_i, // basic instruction, else applied
  input wire logic req_coil_i, // timer or counter coil with set value
  input wire oiag_class_e sv_class_i, // set-value device class
  input wire logic [15:0] sv_base_i, // set-value base number
  input wire logic sv_idx_en_i, // set value is indexed
  input wire logic [2:0] sv_idx_sel_i, // set-value index register
  input wire logic sv_idx_high_i, // set value uses high kind
  output logic ack_o, // one-cycle answer pulse
  output logic [31:0] ea_o, // effective operand number
  output logic [31:0] sv_ea_o, // effective set-value number
  output logic [2:0] unit_o, // buffer memory unit, never offset
  output logic wide_o, // operand width is 32 bits
  output logic err_o, // request refused
  output oiag_err_t err_cause_o // refusal cause
);
  // elaboration check: selects are three bits wide
  if (NUM_IDX != `OIAG_IDX_REGS) begin : g_bad_num
    $error("NUM_IDX must be 8");
  end

  logic [31:0] pair_a;
  logic [31:0] pair_b;

  // index storage; written by the program ahead of use
  oiag_index_file #(.NUM_IDX(NUM_IDX)) u_idx (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .we_i(idx_we_i),
    .wsel_i(idx_wsel_i),
    .whigh_i(idx_whigh_i),
    .wwide_i(idx_wwide_i),
    .wdata_i(idx_wdata_i),
    .rsel_a_i(req_idx_sel_i),
    .rsel_b_i(sv_idx_sel_i),
    .pair_a_o(pair_a),
    .pair_b_o(pair_b)
  );

  // offset of one operand: pair in wide mode, else one sign-extended half
  function automatic logic [31:0] pick_idx(input logic [31:0] pair, input logic high,
                                           input logic wide);
    if (wide) begin
      return pair;
    end else if (high) begin
      return {{16{pair[31]}}, pair[31:16]};
    end
    return {{16{pair[15]}}, pair[15:0]};
  endfunction : pick_idx

  // base plus offset; returns {bad, number}
  function automatic logic [32:0] calc(input oiag_class_e cls, input logic [15:0] base,
                                       input logic [31:0] idx);
    logic [31:0] bin;
    logic [31:0] sum;
    bin = 32'h00000000;
    sum = 32'h00000000;
    if (cls == OIAG_CLS_IN_RELAY || cls == OIAG_CLS_OUT_RELAY) begin
      // octal digits regroup to binary, so the add is plain binary
      bin = {20'h00000, base[14:12], base[10:8], base[6:4], base[2:0]};
      sum = bin + idx;
      return {(sum[31:12] != 20'h00000),
              16'h0000, 1'b0, sum[11:9], 1'b0, sum[8:6], 1'b0, sum[5:3], 1'b0, sum[2:0]};
    end
    sum = {16'h0000, base} + idx;
    return {(cls != OIAG_CLS_CONST) && sum[31], sum};
  endfunction : calc

  logic [32:0] p_res;
  logic [32:0] s_res;
  logic is_c32;
  logic ack_d;
  logic [31:0] ea_d;
  logic [31:0] sv_ea_d;
  logic [2:0] unit_d;
  logic wide_d;
  logic err_d;
  oiag_err_t cause_d;

  // operand and set value are computed side by side from separate selects
  always_comb begin
    p_res = calc(req_class_i, req_base_i, req_idx_en_i ?
                 pick_idx(pair_a, req_idx_high_i, req_wide_i) : 32'h00000000);
    s_res = {1'b0, 32'h00000000};
    if (req_coil_i) begin
      s_res = calc(sv_class_i, sv_base_i, sv_idx_en_i ?
                   pick_idx(pair_b, sv_idx_high_i, 1'b0) : 32'h00000000);
    end
    is_c32 = (req_class_i == OIAG_CLS_COUNTER) && (req_base_i >= `OIAG_C32_FIRST);
    ack_d = req_valid_i;
    ea_d = ea_o;
    sv_ea_d = sv_ea_o;
    unit_d = unit_o;
    wide_d = wide_o;
    err_d = 1'b0;
    cause_d = `OIAG_ERR_NONE;
    if (req_valid_i) begin
      ea_d = p_res[31:0];
      sv_ea_d = s_res[31:0];
      unit_d = req_unit_i;
      wide_d = req_wide_i;
      // refusals, first match wins
      if (req_basic_i && req_idx_en_i && req_class_i == OIAG_CLS_SPECIAL_AUX) begin
        cause_d = `OIAG_ERR_SPM_IDX;
      end else if (req_basic_i && req_idx_en_i && is_c32) begin
        cause_d = `OIAG_ERR_C32_IDX;
      end else if (req_idx_en_i && req_class_i == OIAG_CLS_COUNTER && !is_c32 &&
                   (p_res[32] || p_res[31:0] > {16'h0000, `OIAG_C16_LAST})) begin
        cause_d = `OIAG_ERR_C16_RANGE;
      end else if (req_coil_i && is_c32 && sv_idx_en_i) begin
        cause_d = `OIAG_ERR_SV_C32;
      end else if (req_class_i == OIAG_CLS_BUFFER_MEMORY &&
                   (p_res[32] || p_res[31:0] > `OIAG_BUFMEM_MAX)) begin
        cause_d = `OIAG_ERR_BUF_RANGE;
      end else if (p_res[32] || s_res[32]) begin
        cause_d = `OIAG_ERR_RANGE;
      end
      err_d = (cause_d != `OIAG_ERR_NONE);
    end
  end

  oiag_class_e cls_q;

  // numbers, unit and width hold until the next request; ack, err and cause last one cycle
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o <= 1'b0;
      ea_o <= 32'h00000000;
      sv_ea_o <= 32'h00000000;
      unit_o <= 3'h0;
      wide_o <= 1'b0;
      err_o <= 1'b0;
      err_cause_o <= `OIAG_ERR_NONE;
      cls_q <= OIAG_CLS_IN_RELAY;
    end else if (ce_i) begin
      ack_o <= ack_d;
      ea_o <= ea_d;
      sv_ea_o <= sv_ea_d;
      unit_o <= unit_d;
      wide_o <= wide_d;
      err_o <= err_d;
      err_cause_o <= cause_d;
      if (req_valid_i) begin
        cls_q <= req_class_i;
      end
    end
  end

  // checks; all but chk_width_echo, chk_c16_limit and chk_octal_digits sample with the clock enable high on both ends
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  chk_bufmem_direct: assert property (
    ce_i && req_valid_i && req_class_i == OIAG_CLS_BUFFER_MEMORY && !req_idx_en_i &&
    !req_coil_i && req_base_i <= 16'h7FFE ##1 ce_i |->
    ack_o && !err_o && ea_o == {16'h0000, $past(req_base_i)})
    else $error("direct buffer word not passed through");
  chk_unit_kept: assert property (
    ce_i && req_valid_i && req_class_i == OIAG_CLS_BUFFER_MEMORY ##1 ce_i |->
    unit_o == $past(req_unit_i))
    else $error("buffer unit altered");
  chk_width_echo: assert property (
    ce_i && req_valid_i |=> wide_o == $past(req_wide_i))
    else $error("operand width wrong");
  chk_spm_refused: assert property (
    ce_i && req_valid_i && req_basic_i && req_idx_en_i &&
    req_class_i == OIAG_CLS_SPECIAL_AUX ##1 ce_i |->
    err_o && err_cause_o == `OIAG_ERR_SPM_IDX)
    else $error("indexed special relay accepted");
  chk_c32_refused: assert property (
    ce_i && req_valid_i && req_basic_i && req_idx_en_i && req_class_i == OIAG_CLS_COUNTER &&
    req_base_i >= 16'h00C8 && !(req_class_i == OIAG_CLS_SPECIAL_AUX) ##1 ce_i |-> err_o)
    else $error("indexed 32-bit counter accepted");
  chk_c16_limit: assert property (
    ack_o && !err_o && cls_q == OIAG_CLS_COUNTER && $past(req_base_i) < 16'h00C8 &&
    $past(ce_i) |-> ea_o < 32'h000000C8)
    else $error("16-bit counter became 32-bit");
  chk_octal_digits: assert property (
    ack_o && (cls_q == OIAG_CLS_IN_RELAY || cls_q == OIAG_CLS_OUT_RELAY) |->
    !(ea_o[3] || ea_o[7] || ea_o[11] || ea_o[15]))
    else $error("relay number not octal");
  chk_sv_c32: assert property (
    ce_i && req_valid_i && req_coil_i && sv_idx_en_i && req_class_i == OIAG_CLS_COUNTER &&
    req_base_i >= 16'h00C8 && !req_idx_en_i ##1 ce_i |->
    err_o && err_cause_o == `OIAG_ERR_SV_C32)
    else $error("32-bit counter set value indexed");
  chk_plain_base: assert property (
    ce_i && req_valid_i && req_class_i == OIAG_CLS_DATA_REG && !req_idx_en_i ##1 ce_i |->
    ea_o == {16'h0000, $past(req_base_i)})
    else $error("unindexed data register moved");
  chk_ack_pulse: assert property (
    ce_i && !req_valid_i ##1 ce_i |-> !ack_o)
    else $error("answer without request");
endmodule : oiag_addr_gen
`default_nettype wire

// *** hw/oiag_index_file.sv ***
// index register bank: eight low and eight high halves, two read ports
`timescale 1ns/1ps
`default_nettype none
module oiag_index_file #(
  parameter int NUM_IDX = 8
) (
  input wire logic ref_clk_i, // 100 MHz clock
  input wire logic rstn_i, // async reset, active low
  input wire logic ce_i, // clock enable
  input wire logic we_i, // write strobe
  input wire logic [2:0] wsel_i, // register number written
  input wire logic whigh_i, // write the high half only
  input wire logic wwide_i, // write both halves as one 32-bit value
  input wire logic [31:0] wdata_i, // write data
  input wire logic [2:0] rsel_a_i, // read port a select
  input wire logic [2:0] rsel_b_i, // read port b select
  output logic [31:0] pair_a_o, // {high, low} for port a
  output logic [31:0] pair_b_o // {high, low} for port b
);
  logic [15:0] lo_q [NUM_IDX];
  logic [15:0] lo_d [NUM_IDX];
  logic [15:0] hi_q [NUM_IDX];
  logic [15:0] hi_d [NUM_IDX];

  // next values: a wide write loads both halves so no stale high half remains
  always_comb begin
    for (int i = 0; i < NUM_IDX; i++) begin
      lo_d[i] = lo_q[i];
      hi_d[i] = hi_q[i];
      if (we_i && (32'(wsel_i) == i)) begin
        if (wwide_i) begin
          lo_d[i] = wdata_i[15:0];
          hi_d[i] = wdata_i[31:16];
        end else if (whigh_i) begin
          hi_d[i] = wdata_i[15:0];
        end else begin
          lo_d[i] = wdata_i[15:0];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_IDX; i++) begin
        lo_q[i] <= 16'h0000;
        hi_q[i] <= 16'h0000;
      end
    end else if (ce_i) begin
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end

  // same-numbered halves read as one pair
  assign pair_a_o = {hi_q[rsel_a_i], lo_q[rsel_a_i]};
  assign pair_b_o = {hi_q[rsel_b_i], lo_q[rsel_b_i]};
endmodule : oiag_index_file
`default_nettype wire

// *** shared/oiag_pkg.sv ***
// types shared by the operand index address generator
`default_nettype none
package oiag_pkg;
  // operand device classes
  typedef enum logic [3:0] {
    OIAG_CLS_IN_RELAY,
    OIAG_CLS_OUT_RELAY,
    OIAG_CLS_AUX_RELAY,
    OIAG_CLS_SPECIAL_AUX,
    OIAG_CLS_TIMER,
    OIAG_CLS_COUNTER,
    OIAG_CLS_DATA_REG,
    OIAG_CLS_FILE_REG,
    OIAG_CLS_CONST,
    OIAG_CLS_BUFFER_MEMORY
  } oiag_class_e;
  typedef logic [2:0] oiag_err_t;
endpackage : oiag_pkg
`default_nettype wire

// *** shared/oiag_regs.svh ***
// constants for the operand index address generator
`ifndef OIAG_REGS_SVH
`define OIAG_REGS_SVH
`define OIAG_UNIT_MAX 3'h7
`define OIAG_BUFMEM_MAX 32'h00007FFE
`define OIAG_C16_LAST 16'h00C7
`define OIAG_C32_FIRST 16'h00C8
`define OIAG_IDX_REGS 8
`define OIAG_ERR_NONE 3'h0
`define OIAG_ERR_SPM_IDX 3'h1
`define OIAG_ERR_C32_IDX 3'h2
`define OIAG_ERR_C16_RANGE 3'h3
`define OIAG_ERR_SV_C32 3'h4
`define OIAG_ERR_BUF_RANGE 3'h5
`define OIAG_ERR_RANGE 3'h6
`endif

// *** verif/oiag_prog_model.sv ***
// stand-in for the sequence program that loads the index registers
`timescale 1ns/1ps
`default_nettype none
module oiag_prog_model (
  input wire logic ref_clk_i, // bench clock
  output logic we_o, // index write strobe
  output logic [2:0] sel_o, // register number
  output logic high_o, // high kind
  output logic wide_o, // both halves
  output logic [31:0] data_o // write data
);
  logic [15:0] lo_q [8];
  logic [15:0] hi_q [8];
  // idle data and select lines flip so a stale value never looks valid
  initial begin
    we_o = 1'b0;
    sel_o = 3'h0;
    high_o = 1'b0;
    wide_o = 1'b0;
    data_o = 32'h0;
    foreach (lo_q[i]) lo_q[i] = 16'h0;
    foreach (hi_q[i]) hi_q[i] = 16'h0;
  end
  // one write, finished before any request that uses it
  task automatic load(input logic [2:0] s, input logic h, input logic w, input logic [31:0] d);
    sel_o = s;
    high_o = h;
    wide_o = w;
    data_o = d;
    we_o = 1'b1;
    @(negedge ref_clk_i);
    we_o = 1'b0;
    data_o = ~d;
    sel_o = ~s;
    if (w || !h) lo_q[s] = d[15:0];
    if (w) hi_q[s] = d[31:16];
    else if (h) hi_q[s] = d[15:0];
  endtask : load
endmodule : oiag_prog_model
`default_nettype wire

// *** verif/operand_index_address_gen_bench.sv ***
// self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
`include "oiag_regs.svh"
module operand_index_address_gen_bench import oiag_pkg::*;;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic req_valid_i = 1'b0;
  oiag_class_e req_class_i = OIAG_CLS_DATA_REG;
  oiag_class_e sv_class_i = OIAG_CLS_DATA_REG;
  logic [15:0] req_base_i = 16'h0;
  logic [15:0] sv_base_i = 16'h0;
  logic [2:0] req_unit_i = 3'h0;
  logic [2:0] req_idx_sel_i = 3'h0;
  logic [2:0] sv_idx_sel_i = 3'h0;
  logic req_idx_en_i = 1'b0;
  logic req_idx_high_i = 1'b0;
  logic req_wide_i = 1'b0;
  logic req_basic_i = 1'b0;
  logic req_coil_i = 1'b0;
  logic sv_idx_en_i = 1'b0;
  logic sv_idx_high_i = 1'b0;
  logic idx_we, idx_high, idx_wide, ack, wide, err;
  logic [2:0] idx_sel, unit;
  logic [31:0] idx_data, ea, sv_ea, ob, r;
  oiag_err_t cause;
  int fails = 0;
  int total_checks = 0;
  int seed = 32'hF829C8DD;
  int n, b, v;
  // clock at 100 MHz
  initial forever #5 ref_clk_i = ~ref_clk_i;
  oiag_prog_model pm (.ref_clk_i(ref_clk_i), .we_o(idx_we), .sel_o(idx_sel),
    .high_o(idx_high), .wide_o(idx_wide), .data_o(idx_data));
  oiag_addr_gen #(.NUM_IDX(8)) dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .idx_we_i(idx_we), .idx_wsel_i(idx_sel), .idx_whigh_i(idx_high), .idx_wwide_i(idx_wide),
    .idx_wdata_i(idx_data), .req_valid_i(req_valid_i), .req_class_i(req_class_i),
    .req_base_i(req_base_i), .req_unit_i(req_unit_i), .req_idx_en_i(req_idx_en_i),
    .req_idx_sel_i(req_idx_sel_i), .req_idx_high_i(req_idx_high_i), .req_wide_i(req_wide_i),
    .req_basic_i(req_basic_i), .req_coil_i(req_coil_i), .sv_class_i(sv_class_i),
    .sv_base_i(sv_base_i), .sv_idx_en_i(sv_idx_en_i), .sv_idx_sel_i(sv_idx_sel_i),
    .sv_idx_high_i(sv_idx_high_i), .ack_o(ack), .ea_o(ea), .sv_ea_o(sv_ea), .unit_o(unit),
    .wide_o(wide), .err_o(err), .err_cause_o(cause));
  // relay numbers travel as one octal digit per nibble
  function automatic logic [31:0] to_oct(input int x);
    logic [31:0] o;
    o = 32'h0;
    for (int i = 0; i < 8; i++) o[4*i+:4] = {1'b0, 3'((x >> (3 * i)) & 7)};
    return o;
  endfunction : to_oct
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // indexed request: basic, 16-bit, no coil
  task automatic set_req(input oiag_class_e c, input logic [15:0] bs, input logic [2:0] s);
    req_class_i = c;
    req_base_i = bs;
    req_idx_en_i = 1'b1;
    req_idx_sel_i = s;
    req_idx_high_i = 1'b0;
    req_wide_i = 1'b0;
    req_basic_i = 1'b1;
    req_coil_i = 1'b0;
    sv_idx_en_i = 1'b0;
  endtask : set_req
  // one request, bounded wait for its answer
  task automatic fire(input logic [31:0] e, input logic [31:0] es, input logic ee,
    input logic [2:0] ec, input string nm);
    // one idle edge first so valid never falls and rises in one time step
    @(negedge ref_clk_i);
    req_valid_i = 1'b1;
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 4) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 4) begin
      fails++;
      tally_and_finish();
    end else begin
      chk("ea", ea, e);
      chk("sv_ea", sv_ea, es);
      chk("err", {31'h0, err}, {31'h0, ee});
      chk("cause", {29'h0, cause}, {29'h0, ec});
      chk("unit", {29'h0, unit}, {29'h0, req_unit_i});
      chk("wide", {31'h0, wide}, {31'h0, req_wide_i});
      $display("test %s done", nm);
    end
  endtask : fire
  initial begin
    repeat (6) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    chk("ack_rst", {31'h0, ack}, 32'h0);
    set_req(OIAG_CLS_DATA_REG, 16'h5, 3'h1);
    fire(32'h5, 32'h0, 1'b0, 3'h0, "cleared");
    pm.load(3'h3, 1'b0, 1'b0, 32'hA);
    set_req(OIAG_CLS_DATA_REG, 16'h0, 3'h3);
    fire(32'hA, 32'h0, 1'b0, 3'h0, "low");
    pm.load(3'h2, 1'b1, 1'b0, 32'h7);
    set_req(OIAG_CLS_DATA_REG, 16'h0, 3'h2);
    req_idx_high_i = 1'b1;
    fire(32'h7, 32'h0, 1'b0, 3'h0, "high");
    pm.load(3'h0, 1'b0, 1'b0, 32'h8);
    set_req(OIAG_CLS_IN_RELAY, 16'h0, 3'h0);
    fire(32'h10, 32'h0, 1'b0, 3'h0, "oct8");
    pm.load(3'h0, 1'b0, 1'b0, 32'h10);
    fire(32'h20, 32'h0, 1'b0, 3'h0, "oct16");
    pm.load(3'h0, 1'b0, 1'b0, 32'h5);
    set_req(OIAG_CLS_OUT_RELAY, 16'h0, 3'h0);
    req_basic_i = 1'b0;
    fire(32'h5, 32'h0, 1'b0, 3'h0, "applied");
    set_req(OIAG_CLS_AUX_RELAY, 16'h0, 3'h0);
    fire(32'h5, 32'h0, 1'b0, 3'h0, "aux");
    pm.load(3'h1, 1'b0, 1'b0, 32'h6);
    set_req(OIAG_CLS_BUFFER_MEMORY, 16'h7FF8, 3'h1);
    req_unit_i = 3'h7;
    fire(32'h7FFE, 32'h0, 1'b0, 3'h0, "bufmax");
    pm.load(3'h1, 1'b0, 1'b0, 32'h7);
    fire(32'h7FFF, 32'h0, 1'b1, `OIAG_ERR_BUF_RANGE, "bufover");
    set_req(OIAG_CLS_BUFFER_MEMORY, 16'h7FFE, 3'h1);
    req_idx_en_i = 1'b0;
    req_unit_i = 3'h2;
    fire(32'h7FFE, 32'h0, 1'b0, 3'h0, "bufdirect");
    pm.load(3'h4, 1'b0, 1'b1, 32'h00010002);
    set_req(OIAG_CLS_DATA_REG, 16'h0, 3'h4);
    req_wide_i = 1'b1;
    fire(32'h00010002, 32'h0, 1'b0, 3'h0, "pair");
    // a low half of all ones is minus one once sign-extended
    pm.load(3'h5, 1'b0, 1'b0, 32'hFFFF);
    set_req(OIAG_CLS_DATA_REG, 16'h3, 3'h5);
    fire(32'h2, 32'h0, 1'b0, 3'h0, "negok");
    set_req(OIAG_CLS_DATA_REG, 16'h0, 3'h5);
    fire(32'hFFFFFFFF, 32'h0, 1'b1, `OIAG_ERR_RANGE, "negbad");
    set_req(OIAG_CLS_DATA_REG, 16'h1234, 3'h5);
    req_idx_en_i = 1'b0;
    fire(32'h1234, 32'h0, 1'b0, 3'h0, "plain");
    pm.load(3'h0, 1'b0, 1'b0, 32'hA);
    set_req(OIAG_CLS_SPECIAL_AUX, 16'h0, 3'h0);
    fire(32'hA, 32'h0, 1'b1, `OIAG_ERR_SPM_IDX, "spm");
    set_req(OIAG_CLS_COUNTER, 16'hC8, 3'h0);
    fire(32'hD2, 32'h0, 1'b1, `OIAG_ERR_C32_IDX, "c32");
    set_req(OIAG_CLS_COUNTER, 16'hBE, 3'h0);
    fire(32'hC8, 32'h0, 1'b1, `OIAG_ERR_C16_RANGE, "c16over");
    pm.load(3'h0, 1'b0, 1'b0, 32'h9);
    fire(32'hC7, 32'h0, 1'b0, 3'h0, "c16last");
    pm.load(3'h2, 1'b0, 1'b0, 32'h14);
    set_req(OIAG_CLS_TIMER, 16'h0, 3'h3);
    req_coil_i = 1'b1;
    sv_idx_en_i = 1'b1;
    sv_idx_sel_i = 3'h2;
    fire(32'hA, 32'h14, 1'b0, 3'h0, "coil");
    sv_idx_high_i = 1'b1;
    fire(32'hA, 32'h7, 1'b0, 3'h0, "coilhigh");
    sv_idx_high_i = 1'b0;
    set_req(OIAG_CLS_COUNTER, 16'hC8, 3'h3);
    req_idx_en_i = 1'b0;
    req_coil_i = 1'b1;
    sv_idx_en_i = 1'b1;
    fire(32'hC8, 32'h14, 1'b1, `OIAG_ERR_SV_C32, "coil32");
    // frozen clock enable must swallow the request; let the last ack clear first
    @(negedge ref_clk_i);
    ce_i = 1'b0;
    req_valid_i = 1'b1;
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    @(negedge ref_clk_i);
    chk("ack_frozen", {31'h0, ack}, 32'h0);
    ce_i = 1'b1;
    repeat (24) begin
      r = $random(seed);
      b = int'(r[24:16]);
      v = int'(r[15:8]);
      pm.load(r[2:0], 1'b0, 1'b0, {24'h0, r[15:8]});
      req_unit_i = r[27:25];
      ob = to_oct(b);
      if (r[31]) begin
        set_req(OIAG_CLS_IN_RELAY, ob[15:0], r[2:0]);
        fire(to_oct(b + v), 32'h0, 1'b0, 3'h0, "rnd_relay");
      end else begin
        set_req(OIAG_CLS_DATA_REG, 16'(b), r[2:0]);
        fire(32'(b + v), 32'h0, 1'b0, 3'h0, "rnd_data");
      end
    end
    tally_and_finish();
  end
endmodule : operand_index_address_gen_bench
`default_nettype wire
